// ### flash_cmd_pkg.sv
// constants and types for the serial flash command decoder
package flash_cmd_pkg;

   // ==========================================================
   // opcodes
   localparam logic [7:0] op_read_fast = 8'h1b;
   localparam logic [7:0] op_read = 8'h0b;
   localparam logic [7:0] op_read_slow = 8'h03;
   localparam logic [7:0] op_read_dual = 8'h3b;
   localparam logic [7:0] op_erase_4k = 8'h20;
   localparam logic [7:0] op_erase_32k = 8'h52;
   localparam logic [7:0] op_erase_64k = 8'hd8;
   localparam logic [7:0] op_chip_erase_a = 8'h60;
   localparam logic [7:0] op_chip_erase_b = 8'hc7;
   localparam logic [7:0] op_program = 8'h02;
   localparam logic [7:0] op_program_dual = 8'ha2;
   localparam logic [7:0] op_suspend = 8'hb0;
   localparam logic [7:0] op_resume = 8'hd0;
   localparam logic [7:0] op_write_en = 8'h06;
   localparam logic [7:0] op_write_dis = 8'h04;
   localparam logic [7:0] op_protect = 8'h36;
   localparam logic [7:0] op_unprotect = 8'h39;
   localparam logic [7:0] op_read_protect = 8'h3c;
   localparam logic [7:0] op_lockdown = 8'h33;
   localparam logic [7:0] op_freeze = 8'h34;
   localparam logic [7:0] op_read_lockdown = 8'h35;
   localparam logic [7:0] op_otp_write = 8'h9b;
   localparam logic [7:0] op_otp_read = 8'h77;
   localparam logic [7:0] op_status_read = 8'h05;
   localparam logic [7:0] op_status_wr1 = 8'h01;
   localparam logic [7:0] op_status_wr2 = 8'h31;
   localparam logic [7:0] op_soft_reset = 8'hf0;
   localparam logic [7:0] op_id_read = 8'h9f;
   localparam logic [7:0] op_power_down = 8'hb9;
   localparam logic [7:0] op_power_up = 8'hab;

   // ==========================================================
   // geometry
   localparam int addr_bytes = 3;
   localparam int array_addr_w = 21;
   localparam logic [20:0] addr_reset = 21'h000000;
   localparam logic [7:0] byte_reset = 8'h00;

   // byte phase reported to command units
   typedef enum logic [5:0] {
      st_idle = 6'b000001,
      st_opcode = 6'b000010,
      st_address = 6'b000100,
      st_dummy = 6'b001000,
      st_data = 6'b010000,
      st_ignore = 6'b100000
   } phase_t;

   // decoded shape of a command
   typedef struct packed {
      logic known;
      logic has_addr;
      logic [1:0] dummy;
      logic dual_in;
      logic dual_out;
   } shape_t;

endpackage

// ### flash_cmd_decoder.sv
// serial flash front end: frames, shifts and decodes commands
//Contract
//- a frame starts only once chip select goes active; first 8 bits are opcode
//- every byte is shifted most significant bit first, both directions
//- chip select going inactive ends the current frame
//- an unknown opcode starts nothing
//- after an unknown opcode input is ignored until chip select toggles
//- chip select lost before opcode and address complete means nothing happens
//- top three address bits are dropped; 21 bits reach the array
//- 1Bh fast read: address, two dummy bytes, data
//- 0Bh read: address, one dummy byte, data
//- 03h slow read: address, no dummy, data
//- 3Bh dual output read: address, one dummy, data
//- 20h 52h D8h block erase take address only
//- 60h and C7h chip erase take nothing further
//- 02h and A2h program take address then data bytes
//- B0h suspend and D0h resume are opcode only
//- 06h write enable and 04h write disable are opcode only
//- 36h 39h take address; 3Ch takes address then returns bytes
//- 33h 34h take address plus one byte; 35h address then returns bytes
//- 9Bh takes address and data; 77h address, two dummies, data
//- 05h returns status; 01h and 31h take one byte, no address
//- F0h takes one byte; 9Fh returns id; B9h ABh opcode only
//- input sampled on rising clock edge, output changed on falling edge
//- dual commands turn the unused lane around into input or output
`timescale 1ns/100ps
module flash_cmd_decoder
   import flash_cmd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic sck,
   input wire logic cs_b,
   input wire logic input_lane_bidir_in,
   output logic input_lane_bidir_out,
   output logic input_lane_bidir_oe,
   input wire logic output_lane_bidir_in,
   output logic output_lane_bidir_out,
   output logic output_lane_bidir_oe,
   input wire logic [7:0] tx_byte,
   output logic tx_load,
   output logic [7:0] opcode,
   output logic [20:0] address,
   output logic [5:0] phase,
   output logic cmd_start,
   output logic frame_end,
   output logic [7:0] rx_byte,
   output logic rx_valid,
   output logic [2:0] bit_count
);

   // ==========================================================
   // pin synchronisers: three stages, change taken when 2nd and 3rd agree
   logic [2:0] sck_s;
   logic [2:0] cs_s;
   logic [2:0] si_s;
   logic [2:0] so_s;
   logic sck_q;
   logic cs_q;
   logic si_q;
   logic so_q;

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         sck_s <= 3'h0;
         cs_s <= 3'h7;
         si_s <= 3'h0;
         so_s <= 3'h0;
      end else begin
         sck_s <= {sck_s[1:0], sck};
         cs_s <= {cs_s[1:0], cs_b};
         si_s <= {si_s[1:0], input_lane_bidir_in};
         so_s <= {so_s[1:0], output_lane_bidir_in};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         sck_q <= 1'b0;
         cs_q <= 1'b1;
         si_q <= 1'b0;
         so_q <= 1'b0;
      end else begin
         if (sck_s[1] == sck_s[2]) sck_q <= sck_s[2];
         if (cs_s[1] == cs_s[2]) cs_q <= cs_s[2];
         if (si_s[1] == si_s[2]) si_q <= si_s[2];
         if (so_s[1] == so_s[2]) so_q <= so_s[2];
      end
   end

   logic sck_d;
   logic cs_d;
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         sck_d <= 1'b0;
         cs_d <= 1'b1;
      end else begin
         sck_d <= sck_q;
         cs_d <= cs_q;
      end
   end

   wire sck_rise = sck_q & ~sck_d;
   wire sck_fall = ~sck_q & sck_d;
   wire cs_fall = ~cs_q & cs_d;
   wire cs_rise = cs_q & ~cs_d;

   // ==========================================================
   // opcode decode table
   function automatic shape_t decode(input logic [7:0] op);
      shape_t s;
      s = '0;
      s.known = 1'b1;
      case (op)
         op_read_fast, op_otp_read: begin
            s.has_addr = 1'b1;
            s.dummy = 2'd2;
         end
         op_read: begin
            s.has_addr = 1'b1;
            s.dummy = 2'd1;
         end
         op_read_dual: begin
            s.has_addr = 1'b1;
            s.dummy = 2'd1;
            s.dual_out = 1'b1;
         end
         op_program_dual: begin
            s.has_addr = 1'b1;
            s.dual_in = 1'b1;
         end
         op_read_slow, op_erase_4k, op_erase_32k, op_erase_64k, op_program,
         op_protect, op_unprotect, op_read_protect, op_lockdown, op_freeze,
         op_read_lockdown, op_otp_write:
            s.has_addr = 1'b1;
         op_chip_erase_a, op_chip_erase_b, op_suspend, op_resume,
         op_write_en, op_write_dis, op_status_read, op_status_wr1,
         op_status_wr2, op_soft_reset, op_id_read, op_power_down,
         op_power_up:
            s.known = 1'b1;
         default:
            s.known = 1'b0;
      endcase
      return s;
   endfunction

   // ==========================================================
   // frame state machine
   phase_t state;
   shape_t shape;
   logic [7:0] shreg;
   logic [1:0] byte_idx;
   logic [7:0] next_byte;
   logic byte_done;
   shape_t next_shape;

   // dual-input data phase takes two bits per edge, so a byte closes after four
   wire dual_rx = (state == st_data) && shape.dual_in;
   assign next_byte = dual_rx ? {shreg[5:0], so_q, si_q} : {shreg[6:0], si_q};
   assign byte_done = dual_rx ? (bit_count[1:0] == 2'h3) : (bit_count == 3'h7);
   assign next_shape = decode(next_byte);

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         state <= st_idle;
         shape <= '0;
         shreg <= byte_reset;
         bit_count <= 3'h0;
         byte_idx <= 2'h0;
         opcode <= byte_reset;
         address <= addr_reset;
         cmd_start <= 1'b0;
         rx_valid <= 1'b0;
         rx_byte <= byte_reset;
      end else begin
         cmd_start <= 1'b0;
         rx_valid <= 1'b0;
         if (cs_rise) begin
            state <= st_idle;
            bit_count <= 3'h0;
         end else if (cs_fall) begin
            state <= st_opcode;
            bit_count <= 3'h0;
            byte_idx <= 2'h0;
         end else if (sck_rise && !cs_q) begin
            case (state)
               st_opcode: begin
                  shreg <= next_byte;
                  bit_count <= bit_count + 3'h1;
                  if (byte_done) begin
                     opcode <= next_byte;
                     shape <= next_shape;
                     byte_idx <= 2'h0;
                     if (!next_shape.known) begin
                        state <= st_ignore;
                     end else if (next_shape.has_addr) begin
                        state <= st_address;
                     end else begin
                        state <= st_data;
                        cmd_start <= 1'b1;
                     end
                  end
               end
               st_address: begin
                  shreg <= next_byte;
                  bit_count <= bit_count + 3'h1;
                  if (byte_done) begin
                     // upper three bits fall off the 21-bit register
                     address <= {address[12:0], next_byte};
                     if (byte_idx == 2'(addr_bytes - 1)) begin
                        byte_idx <= 2'h0;
                        // command only begins once the full address is in
                        cmd_start <= 1'b1;
                        state <= (shape.dummy != 2'd0) ? st_dummy : st_data;
                     end else begin
                        byte_idx <= byte_idx + 2'h1;
                     end
                  end
               end
               st_dummy: begin
                  bit_count <= bit_count + 3'h1;
                  if (byte_done) begin
                     if (byte_idx == shape.dummy - 2'd1) begin
                        state <= st_data;
                     end
                     byte_idx <= byte_idx + 2'h1;
                  end
               end
               st_data: begin
                  shreg <= next_byte;
                  bit_count <= dual_rx ? {1'b0, bit_count[1:0] + 2'h1} : bit_count + 3'h1;
                  if (byte_done) begin
                     bit_count <= 3'h0;
                     rx_byte <= next_byte;
                     rx_valid <= 1'b1;
                  end
               end
               st_ignore: state <= st_ignore;
               st_idle: state <= st_idle;
               default: state <= st_idle;
            endcase
         end
      end
   end

   assign phase = state;

   // ==========================================================
   // output lanes: shift on the falling edge
   logic [7:0] tx_sh;
   // single lane needs eight falls per byte, dual lane four
   logic [2:0] tx_cnt;
   logic tx_first;
   wire tx_phase = (state == st_data) && !cs_q;

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         tx_sh <= byte_reset;
         tx_cnt <= 3'h0;
         tx_first <= 1'b1;
         tx_load <= 1'b0;
         output_lane_bidir_out <= 1'b0;
         input_lane_bidir_out <= 1'b0;
         output_lane_bidir_oe <= 1'b0;
         input_lane_bidir_oe <= 1'b0;
      end else begin
         tx_load <= 1'b0;
         // dual-input program turns the output lane into an input
         output_lane_bidir_oe <= tx_phase && !shape.dual_in;
         input_lane_bidir_oe <= tx_phase && shape.dual_out;
         if (!tx_phase) begin
            tx_first <= 1'b1;
            tx_cnt <= 3'h0;
            if (cs_q) begin
               output_lane_bidir_oe <= 1'b0;
               input_lane_bidir_oe <= 1'b0;
            end
         end else if (sck_fall) begin
            if (tx_first || tx_cnt == 3'h0) begin
               output_lane_bidir_out <= tx_byte[7];
               input_lane_bidir_out <= tx_byte[6];
               tx_sh <= shape.dual_out ? {tx_byte[5:0], 2'b00} : {tx_byte[6:0], 1'b0};
               tx_load <= 1'b1;
               tx_first <= 1'b0;
               tx_cnt <= shape.dual_out ? 3'h3 : 3'h7;
            end else begin
               output_lane_bidir_out <= tx_sh[7];
               input_lane_bidir_out <= tx_sh[6];
               tx_sh <= shape.dual_out ? {tx_sh[5:0], 2'b00} : {tx_sh[6:0], 1'b0};
               tx_cnt <= tx_cnt - 3'h1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         frame_end <= 1'b0;
      end else begin
         frame_end <= cs_rise;
      end
   end

endmodule

// ### spi_host_model.sv
// behavioural spi host that frames and clocks commands in mode 0
`timescale 1ns/100ps
module spi_host_model (
   input wire logic clk_sys,
   output logic sck,
   output logic cs_b,
   output logic si,
   output logic so_q,
   output logic so_oe,
   input wire logic so_in,
   input wire logic si_in
);
   initial begin
      sck = 1'b0;
      cs_b = 1'b1;
      si = 1'b0;
      so_q = 1'b0;
      so_oe = 1'b0;
   end

   // ==========================================================
   // framing
   task automatic start;
      @(posedge clk_sys);
      cs_b <= 1'b0;
      repeat (8) @(posedge clk_sys);
   endtask

   task automatic stop;
      repeat (8) @(posedge clk_sys);
      cs_b <= 1'b1;
      so_oe <= 1'b0;
      repeat (8) @(posedge clk_sys);
   endtask

   // ==========================================================
   // one byte; m: 0 single, 1 dual read, 2 dual write
   // device output is read late in the high half: its edge detector lags sck
   task automatic xfer(input logic [7:0] tx, input logic [1:0] m, output logic [7:0] rx);
      int i;
      rx = 8'h00;
      for (i = 7; i >= 0; i = i - ((m != 2'h0) ? 2 : 1)) begin
         @(posedge clk_sys);
         si <= tx[(m != 2'h0) ? i - 1 : i];
         so_q <= tx[i];
         so_oe <= (m == 2'h2);
         repeat (3) @(posedge clk_sys);
         sck <= 1'b1;
         repeat (4) @(posedge clk_sys);
         rx = (m != 2'h0) ? {rx[5:0], so_in, si_in} : {rx[6:0], so_in};
         sck <= 1'b0;
      end
   endtask
endmodule

// ### flash_cmd_decoder_properties.sv
// assertions on the command decoder ports
`timescale 1ns/100ps
module flash_cmd_decoder_properties
   import flash_cmd_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic cs_b,
   input wire logic input_lane_bidir_oe,
   input wire logic output_lane_bidir_oe,
   input wire logic tx_load,
   input wire logic [7:0] opcode,
   input wire logic [5:0] phase,
   input wire logic cmd_start,
   input wire logic frame_end
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   // ==========================================================
   // framing and decode
   AST_FRAME_END: assert property ($rose(cs_b) |-> ##[1:8] frame_end)
      else $error("frame end missing after chip select release");
   AST_START_IN_FRAME: assert property (cmd_start |-> !cs_b)
      else $error("command start outside a frame");
   AST_START_PULSE: assert property (cmd_start |=> !cmd_start)
      else $error("command start longer than one cycle");
   AST_IGNORE_NO_START: assert property (phase == st_ignore |-> !cmd_start)
      else $error("command start while ignoring");
   AST_IGNORE_STAYS: assert property (phase == st_ignore |=>
      phase inside {st_ignore, st_idle})
      else $error("ignore left without frame end");
   AST_OPCODE_HOLD: assert property (!cs_b && phase inside {st_dummy, st_data} |=>
      $stable(opcode))
      else $error("opcode changed in mid frame");

   // ==========================================================
   // lane direction
   AST_IDLE_QUIET: assert property (phase == st_idle && $past(phase) == st_idle |->
      !output_lane_bidir_oe && !input_lane_bidir_oe)
      else $error("lane driven while idle");
   AST_SI_DRIVE: assert property (input_lane_bidir_oe |-> opcode == op_read_dual)
      else $error("input lane driven outside dual read");
   AST_SO_DIR: assert property (output_lane_bidir_oe |-> opcode != op_program_dual)
      else $error("output lane driven in dual program");
   AST_LOAD_DATA: assert property (tx_load |-> phase == st_data)
      else $error("byte loaded outside data phase");

   C_START: cover property (cmd_start);
   C_IGNORE: cover property (phase == st_ignore);
   C_DUAL: cover property (input_lane_bidir_oe);
   C_LOAD: cover property (tx_load);
endmodule

// ### flash_cmd_decoder_bench.sv
// self-checking bench for the command decoder
`timescale 1ns/100ps
module flash_cmd_decoder_bench
   import flash_cmd_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] tx_byte = 8'h96;
   logic sck, cs_b, si, so_q, so_oe, si_out, si_oe, so_out, so_doe, si_w, so_w;
   logic tx_load, cmd_start, frame_end, rx_valid;
   logic [7:0] opcode, rx_byte, rxd, rx;
   logic [20:0] address;
   logic [5:0] phase;
   logic [2:0] bit_count;
   logic [23:0] adr = 24'hfa5c3e;
   int failures = 0, n_tests = 0, n_start = 0, n_rx = 0, cycles = 0, s0;
   // {known, has address, opcode}
   logic [9:0] rows [32] = '{10'h31b, 10'h30b, 10'h303, 10'h33b, 10'h320, 10'h352,
      10'h3d8, 10'h302, 10'h3a2, 10'h336, 10'h339, 10'h33c, 10'h333, 10'h334, 10'h335,
      10'h39b, 10'h377, 10'h260, 10'h2c7, 10'h2b0, 10'h2d0, 10'h206, 10'h204, 10'h205,
      10'h201, 10'h231, 10'h2f0, 10'h29f, 10'h2b9, 10'h2ab, 10'h0ff, 10'h0aa};

   // undriven lanes show the inverse of the last value
   assign si_w = si_oe ? si_out : si;
   assign so_w = so_doe ? so_out : (so_oe ? so_q : ~so_out);

   flash_cmd_decoder flash_cmd_decoder_inst (.clk_sys(clk_sys), .rst_b(rst_b), .sck(sck),
      .cs_b(cs_b), .input_lane_bidir_in(si_w), .input_lane_bidir_out(si_out),
      .input_lane_bidir_oe(si_oe), .output_lane_bidir_in(so_w),
      .output_lane_bidir_out(so_out), .output_lane_bidir_oe(so_doe), .tx_byte(tx_byte),
      .tx_load(tx_load), .opcode(opcode), .address(address), .phase(phase),
      .cmd_start(cmd_start), .frame_end(frame_end), .rx_byte(rx_byte),
      .rx_valid(rx_valid), .bit_count(bit_count));

   spi_host_model spi_host_model_inst (.clk_sys(clk_sys), .sck(sck), .cs_b(cs_b),
      .si(si), .so_q(so_q), .so_oe(so_oe), .so_in(so_w), .si_in(si_w));

   initial begin
      forever #20 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cmd_start === 1'b1) n_start <= n_start + 1;
      if (rx_valid === 1'b1) begin
         n_rx <= n_rx + 1;
         rxd <= rx_byte;
      end
      if (cycles == 40000) begin
         failures++;
         final_report();
      end
   end

   // ==========================================================
   // helpers
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic send(input logic [7:0] b);
      spi_host_model_inst.xfer(b, 2'h0, rx);
   endtask

   task automatic addr3;
      for (int i = 0; i < 3; i++) send(adr[23 - 8 * i -: 8]);
   endtask

   task automatic rd(input logic [7:0] op, input int nd, input logic [1:0] m);
      spi_host_model_inst.start();
      send(op);
      addr3();
      for (int i = 0; i < nd; i++) begin
         repeat (8) @(posedge clk_sys);
         check("dummy phase", phase, st_dummy);
         send(8'h00);
      end
      repeat (8) @(posedge clk_sys);
      check("data phase", phase, st_data);
      check("bit count", bit_count, 3'h0);
      spi_host_model_inst.xfer(8'h00, m, rx);
      check("read byte", rx, tx_byte);
      spi_host_model_inst.stop();
   endtask

   task automatic pg(input logic [7:0] op, input logic [1:0] m);
      s0 = n_rx;
      spi_host_model_inst.start();
      send(op);
      addr3();
      spi_host_model_inst.xfer(8'h5a, m, rx);
      spi_host_model_inst.stop();
      check("rx count", n_rx - s0, 1);
      check("rx byte", rxd, 8'h5a);
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ==========================================================
   // main sequence
   initial begin
      repeat (5) @(posedge clk_sys);
      check("reset phase", phase, st_idle);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk_sys);
      foreach (rows[k]) begin
         s0 = n_start;
         spi_host_model_inst.start();
         send(rows[k][7:0]);
         if (rows[k][8]) addr3();
         repeat (8) @(posedge clk_sys);
         if (!rows[k][9]) check("ignore", phase, st_ignore);
         spi_host_model_inst.stop();
         check("opcode", opcode, rows[k][7:0]);
         check("start", n_start - s0, rows[k][9]);
         if (rows[k][9] & rows[k][8]) check("address", address, 21'h1a5c3e);
         check("idle", phase, st_idle);
      end
      $display("test table done");
      s0 = n_start;
      spi_host_model_inst.start();
      send(op_erase_4k);
      send(8'h01);
      spi_host_model_inst.stop();
      check("truncated", n_start - s0, 0);
      spi_host_model_inst.start();
      send(8'hff);
      send(op_write_en);
      repeat (8) @(posedge clk_sys);
      check("still ignoring", phase, st_ignore);
      spi_host_model_inst.stop();
      spi_host_model_inst.start();
      send(op_write_en);
      spi_host_model_inst.stop();
      check("after ignore", n_start - s0, 1);
      $display("test abort done");
      // reset in mid frame: the frame is dropped and nothing starts
      s0 = n_start;
      spi_host_model_inst.start();
      send(op_read_slow);
      send(8'h12);
      rst_b <= 1'b0;
      spi_host_model_inst.stop();
      check("reset opcode", opcode, byte_reset);
      check("reset address", address, addr_reset);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk_sys);
      check("reset idle", phase, st_idle);
      check("reset start", n_start - s0, 0);
      $display("test reset done");
      rd(op_read_fast, 2, 2'h0);
      rd(op_read, 1, 2'h0);
      rd(op_read_slow, 0, 2'h0);
      rd(op_read_dual, 1, 2'h1);
      rd(op_otp_read, 2, 2'h0);
      $display("test read done");
      pg(op_program, 2'h0);
      pg(op_program_dual, 2'h2);
      $display("test program done");
      final_report();
   end

endmodule

bind flash_cmd_decoder flash_cmd_decoder_properties flash_cmd_decoder_properties_inst (
   .clk_sys, .rst_b, .cs_b, .input_lane_bidir_oe, .output_lane_bidir_oe, .tx_load,
   .opcode, .phase, .cmd_start, .frame_end);
